// File: rtl/psr_cfg.svh
// Constants of the pixel shutter and readout control block.
// Included by the package and by the design modules; definitions only.
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH

// Serial configuration word
`define PSR_CFG_W       32
`define PSR_CFG_RST     32'h0000_0000
`define PSR_Y_DIR_BIT   0
`define PSR_Y_START_LSB 1
`define PSR_X_START_LSB 14
`define PSR_START_W     10

// Row and column address counters
`define PSR_ADDR_W      11
`define PSR_ADDR_RST    11'h000
`define PSR_ROWS        2048
`define PSR_COLS        2048
// Pixels selected per pixel clock period
`define PSR_PIX_PER_CLK 2

// Pin bundle sampled by the core clock
`define PSR_PIN_W       10
`define PSR_PIN_RST     10'h000

`endif

// File: rtl/psr_cfg_shift.sv
// Serial configuration shift register, clocked by the serial clock.
// Assumes the serial clock stands still while the load strobe is high,
// so the word is stable when the core domain copies it.
`timescale 1ns/1ps
`include "psr_cfg.svh"

module psr_cfg_shift (
  input  wire logic                  cfg_sclk,
  input  wire logic                  rst_b,
  input  wire logic                  cfg_sdata,
  output      logic [`PSR_CFG_W-1:0] shift_word
);

  psr_pkg::psr_shift_type state;
  psr_pkg::psr_shift_type next_state;

  always_comb begin
    next_state = state;
    // First bit ends up in the highest position after a full word
    next_state.word = {state.word[`PSR_CFG_W-2:0], cfg_sdata};
  end

  always_ff @(posedge cfg_sclk or negedge rst_b) begin
    if (!rst_b) begin
      state.word <= `PSR_CFG_RST;
    end else begin
      state <= next_state;
    end
  end

  assign shift_word = state.word;

  chk_shift_serial_in: assert property (
    @(posedge cfg_sclk) disable iff (!rst_b)
    ##1 shift_word == {$past(shift_word[`PSR_CFG_W-2:0]), $past(cfg_sdata)}
  ) else $error("shift register did not take the serial bit");

endmodule

// File: rtl/psr_pkg.sv
// Types of the pixel shutter and readout control block.
// Widths come from the guarded constant header.
`include "psr_cfg.svh"

package psr_pkg;

  // State of the core clock domain
  typedef struct packed {
    logic [`PSR_PIN_W-1:0]  pin_s1;
    logic [`PSR_PIN_W-1:0]  pin_s2;
    logic [`PSR_PIN_W-1:0]  pin_q;
    logic                   mem_bias_high;
    logic                   pixel_reset_on;
    logic                   reset_full_level;
    logic                   partial_reset_supply;
    logic                   precharge_on;
    logic                   sample_on;
    logic [`PSR_CFG_W-1:0]  cfg_word;
    logic [`PSR_ADDR_W-1:0] row_addr;
    logic [`PSR_ADDR_W-1:0] col_addr;
    logic                   row_full;
    logic                   col_full;
    logic                   line_end;
    logic                   frame_end;
  } psr_state_type;

  // State of the serial clock domain
  typedef struct packed {
    logic [`PSR_CFG_W-1:0]  word;
  } psr_shift_type;

endpackage

// File: rtl/psr_top.sv
// Pixel array drivers and readout addressing of a snapshot-shutter sensor.
// Assumes an outside controller drives all control pulses; every pin
// except the serial data is asynchronous to mclk.
`timescale 1ns/1ps
`include "psr_cfg.svh"

module psr_top #(
  parameter int ROWS = `PSR_ROWS,
  parameter int COLS = `PSR_COLS
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire logic                   memory_boost_n,
  input  wire logic                   full_reset,
  input  wire logic                   dual_slope_reset,
  input  wire logic                   precharge_n,
  input  wire logic                   sample_n,
  input  wire logic                   frame_sync,
  input  wire logic                   row_clk,
  input  wire logic                   line_sync,
  input  wire logic                   pixel_clk,
  input  wire logic                   cfg_sclk,
  input  wire logic                   cfg_sdata,
  input  wire logic                   cfg_load,
  output      logic                   mem_bias_high,
  output      logic                   pixel_reset_on,
  output      logic                   reset_full_level,
  output      logic                   partial_reset_supply,
  output      logic                   precharge_on,
  output      logic                   sample_on,
  output      logic [`PSR_ADDR_W-1:0] row_addr,
  output      logic [`PSR_ADDR_W-1:0] col_addr,
  output      logic                   line_end,
  output      logic                   frame_end,
  output      logic [`PSR_CFG_W-1:0]  cfg_word
);

  localparam int P_BOOST = 0;
  localparam int P_FULL  = 1;
  localparam int P_DUAL  = 2;
  localparam int P_PRE   = 3;
  localparam int P_SAMP  = 4;
  localparam int P_FSYNC = 5;
  localparam int P_RCLK  = 6;
  localparam int P_LSYNC = 7;
  localparam int P_PCLK  = 8;
  localparam int P_LOAD  = 9;

  localparam logic [`PSR_ADDR_W-1:0] ROW_LAST =
    `PSR_ADDR_W'(ROWS - 1);
  localparam logic [`PSR_ADDR_W-1:0] COL_LAST =
    `PSR_ADDR_W'(COLS - `PSR_PIX_PER_CLK);
  localparam logic [`PSR_ADDR_W-1:0] COL_STEP =
    `PSR_ADDR_W'(`PSR_PIX_PER_CLK);

  psr_pkg::psr_state_type state;
  psr_pkg::psr_state_type next_state;

  logic [`PSR_CFG_W-1:0]   shift_word;
  logic [`PSR_PIN_W-1:0]   pin_in;
  logic [`PSR_PIN_W-1:0]   pin_rise;
  logic [`PSR_START_W-1:0] y_start;
  logic [`PSR_START_W-1:0] x_start;
  logic [`PSR_ADDR_W-1:0]  row_start;
  logic [`PSR_ADDR_W-1:0]  col_start;

  // Serial side runs on its own clock; only the finished word leaves it
  psr_cfg_shift u_shift (
    .cfg_sclk   (cfg_sclk),
    .rst_b      (rst_b),
    .cfg_sdata  (cfg_sdata),
    .shift_word (shift_word)
  );

  assign pin_in = {cfg_load, pixel_clk, line_sync, row_clk, frame_sync,
                   sample_n, precharge_n, dual_slope_reset, full_reset,
                   memory_boost_n};

  // Edges only from the second stage onward
  assign pin_rise  = state.pin_s2 & ~state.pin_q;
  assign y_start   = state.cfg_word[`PSR_Y_START_LSB +: `PSR_START_W];
  assign x_start   = state.cfg_word[`PSR_X_START_LSB +: `PSR_START_W];
  assign row_start = {y_start, 1'b0};
  assign col_start = {x_start, 1'b0};

  always_comb begin
    next_state = state;
    next_state.pin_s1 = pin_in;
    next_state.pin_s2 = state.pin_s1;
    next_state.pin_q  = state.pin_s2;

    // Pixel array drivers: levels follow the synchronised controls
    next_state.mem_bias_high = state.pin_s2[P_BOOST];
    next_state.pixel_reset_on =
      state.pin_s2[P_FULL] | state.pin_s2[P_DUAL];
    next_state.reset_full_level = state.pin_s2[P_FULL];
    next_state.partial_reset_supply =
      state.pin_s2[P_DUAL] & ~state.pin_s2[P_FULL];
    next_state.precharge_on = ~state.pin_s2[P_PRE];
    next_state.sample_on    = ~state.pin_s2[P_SAMP];

    // Shift word is quiet while the load strobe is high
    if (pin_rise[P_LOAD]) begin
      next_state.cfg_word = shift_word;
    end

    next_state.frame_end = 1'b0;
    next_state.line_end  = 1'b0;

    // Frame sync dominates the row clock while it is high
    if (state.pin_s2[P_FSYNC]) begin
      next_state.row_addr = row_start;
      next_state.row_full = (y_start == '0);
    end else if (pin_rise[P_RCLK]) begin
      if (state.row_addr == ROW_LAST) begin
        next_state.frame_end = state.row_full;
        next_state.row_addr  = `PSR_ADDR_RST;
        next_state.row_full  = 1'b0;
      end else begin
        next_state.row_addr = state.row_addr + 1'b1;
      end
    end

    // Line sync likewise dominates the pixel clock
    if (state.pin_s2[P_LSYNC]) begin
      next_state.col_addr = col_start;
      next_state.col_full = (x_start == '0);
    end else if (pin_rise[P_PCLK]) begin
      if (state.col_addr == COL_LAST) begin
        next_state.line_end = state.col_full;
        next_state.col_addr = `PSR_ADDR_RST;
        next_state.col_full = 1'b0;
      end else begin
        next_state.col_addr = state.col_addr + COL_STEP;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state.pin_s1               <= `PSR_PIN_RST;
      state.pin_s2               <= `PSR_PIN_RST;
      state.pin_q                <= `PSR_PIN_RST;
      state.mem_bias_high        <= 1'b0;
      state.pixel_reset_on       <= 1'b0;
      state.reset_full_level     <= 1'b0;
      state.partial_reset_supply <= 1'b0;
      state.precharge_on         <= 1'b0;
      state.sample_on            <= 1'b0;
      state.cfg_word             <= `PSR_CFG_RST;
      state.row_addr             <= `PSR_ADDR_RST;
      state.col_addr             <= `PSR_ADDR_RST;
      state.row_full             <= 1'b0;
      state.col_full             <= 1'b0;
      state.line_end             <= 1'b0;
      state.frame_end            <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign mem_bias_high        = state.mem_bias_high;
  assign pixel_reset_on       = state.pixel_reset_on;
  assign reset_full_level     = state.reset_full_level;
  assign partial_reset_supply = state.partial_reset_supply;
  assign precharge_on         = state.precharge_on;
  assign sample_on            = state.sample_on;
  assign row_addr             = state.row_addr;
  assign col_addr             = state.col_addr;
  assign line_end             = state.line_end;
  assign frame_end            = state.frame_end;
  assign cfg_word             = state.cfg_word;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // Five equal samples cover the sync flops, also just after reset
  chk_bias_follows_boost: assert property (
    $stable(memory_boost_n) [*4] |-> mem_bias_high == memory_boost_n
  ) else $error("memory bias does not follow memory boost");

  chk_reset_any_input: assert property (
    ($stable(dual_slope_reset) && $stable(full_reset)) [*4]
    |-> pixel_reset_on == (dual_slope_reset || full_reset)
  ) else $error("pixel reset does not match reset inputs");

  chk_reset_full_wins: assert property (
    ($stable(full_reset) && full_reset) [*4]
    |-> reset_full_level && !partial_reset_supply
  ) else $error("dual slope level applied during full reset");

  chk_precharge_follows: assert property (
    $stable(precharge_n) [*4] |-> precharge_on == !precharge_n
  ) else $error("precharge output does not follow its input");

  chk_sample_follows: assert property (
    $stable(sample_n) [*4] |-> sample_on == !sample_n
  ) else $error("sample output does not follow its input");

  chk_partial_alone: assert property (
    partial_reset_supply |-> pixel_reset_on && !reset_full_level
  ) else $error("partial supply selected without lone dual reset");

  chk_frame_sync_init: assert property (
    state.pin_s2[P_FSYNC] |=> row_addr == {$past(y_start), 1'b0}
  ) else $error("frame sync did not reload row address");

  chk_row_step_up: assert property (
    pin_rise[P_RCLK] && !state.pin_s2[P_FSYNC] && row_addr != ROW_LAST
    |=> row_addr == $past(row_addr) + 1'b1
  ) else $error("row clock edge did not select next row");

  chk_row_hold_idle: assert property (
    !pin_rise[P_RCLK] && !state.pin_s2[P_FSYNC] |=> $stable(row_addr)
  ) else $error("row address moved without row clock");

  chk_line_sync_init: assert property (
    state.pin_s2[P_LSYNC] |=> col_addr == {$past(x_start), 1'b0}
  ) else $error("line sync did not reload column address");

  chk_col_two_pixels: assert property (
    pin_rise[P_PCLK] && !state.pin_s2[P_LSYNC] && col_addr != COL_LAST
    |=> col_addr == $past(col_addr) + COL_STEP
  ) else $error("pixel clock did not advance two pixels");

  chk_cfg_load_only: assert property (
    !pin_rise[P_LOAD] |=> $stable(cfg_word)
  ) else $error("configuration changed without load edge");

  chk_cfg_load_take: assert property (
    pin_rise[P_LOAD] |=> cfg_word == $past(shift_word)
  ) else $error("load edge did not take the shifted word");

  chk_frame_end_full: assert property (
    frame_end |-> $past(row_addr) == ROW_LAST && $past(state.row_full)
  ) else $error("frame end flag outside a full frame scan");

  chk_line_end_full: assert property (
    line_end |-> $past(col_addr) == COL_LAST && $past(state.col_full)
  ) else $error("line end flag outside a full line scan");

  chk_end_flag_pulse: assert property (
    frame_end |=> !frame_end
  ) else $error("frame end flag longer than one cycle");

  chk_line_end_pulse: assert property (
    line_end |=> !line_end
  ) else $error("line end flag longer than one cycle");

  chk_row_wrap_last: assert property (
    pin_rise[P_RCLK] && !state.pin_s2[P_FSYNC] && row_addr == ROW_LAST
    |=> row_addr == `PSR_ADDR_RST
  ) else $error("row address did not wrap after the last row");

  chk_col_wrap_last: assert property (
    pin_rise[P_PCLK] && !state.pin_s2[P_LSYNC] && col_addr == COL_LAST
    |=> col_addr == `PSR_ADDR_RST
  ) else $error("column address did not wrap after the last pair");

  // A windowed scan never arms the end flags
  chk_row_window_quiet: assert property (
    !state.row_full |=> !frame_end
  ) else $error("frame end flag during windowed readout");

  chk_col_window_quiet: assert property (
    !state.col_full |=> !line_end
  ) else $error("line end flag during windowed readout");

  cov_frame_end: cover property (frame_end);
  cov_line_end: cover property (line_end);
  cov_both_resets: cover property (
    full_reset && dual_slope_reset ##3 reset_full_level);
  cov_cfg_load: cover property (
    pin_rise[P_LOAD] ##1 cfg_word != `PSR_CFG_RST);
  cov_bias_pulse: cover property (
    !mem_bias_high && precharge_on && sample_on);

endmodule

// File: tb/psr_ctl_model.sv
// Camera controller model: drives every control and readout pin.
// Assumes its tasks are called just after a rising edge of mclk.
`timescale 1ns/1ps

module psr_ctl_model (
  input  wire logic mclk,
  output      logic memory_boost_n,
  output      logic full_reset,
  output      logic dual_slope_reset,
  output      logic precharge_n,
  output      logic sample_n,
  output      logic frame_sync,
  output      logic row_clk,
  output      logic line_sync,
  output      logic pixel_clk,
  output      logic cfg_sclk,
  output      logic cfg_sdata,
  output      logic cfg_load
);
  initial begin
    {memory_boost_n, precharge_n, sample_n} = 3'h7;
    {full_reset, dual_slope_reset, frame_sync, row_clk} = 4'h0;
    {line_sync, pixel_clk, cfg_sclk, cfg_sdata, cfg_load} = 5'h00;
  end

  // Every width except the 32 ns serial clock phases in shift is a count of mclk periods
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Order: sample, precharge, boost, dual slope, full reset
  task automatic levels(input logic [4:0] p);
    {sample_n, precharge_n, memory_boost_n, dual_slope_reset,
     full_reset} = p;
  endtask

  // Boost 7.52 us encloses precharge 4 us and sample 5.2 us
  task automatic transfer();
    memory_boost_n = 1'b0;
    tick(2);
    precharge_n = 1'b0;
    tick(50);
    sample_n = 1'b0;
    tick(50);
    precharge_n = 1'b1;
    tick(80);
    sample_n = 1'b1;
    tick(6);
    memory_boost_n = 1'b1;
    tick(2);
    full_reset = 1'b1;
    tick(10);
    full_reset = 1'b0;
    tick(30);
  endtask

  task automatic dual_pulse();
    dual_slope_reset = 1'b1;
    tick(50);
    dual_slope_reset = 1'b0;
    tick(2);
  endtask

  // Slow clock phases so that mclk can sample them
  task automatic step(input bit col, input int n);
    repeat (n) begin
      {row_clk, pixel_clk} = col ? 2'h1 : 2'h2;
      tick(3);
      {row_clk, pixel_clk} = 2'h0;
      tick(3);
    end
  endtask

  task automatic sync(input bit col);
    {frame_sync, line_sync} = col ? 2'h1 : 2'h2;
    tick(3);
    step(col, 1);
    {frame_sync, line_sync} = 2'h0;
    tick(3);
  endtask

  task automatic shift(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      cfg_sdata = w[i];
      #32 cfg_sclk = 1'b1;
      #32 cfg_sclk = 1'b0;
    end
    // No pull on the data line: leave it at the inverse
    cfg_sdata = ~w[0];
    tick(2);
  endtask

  task automatic load();
    cfg_load = 1'b1;
    tick(3);
    cfg_load = 1'b0;
    tick(5);
  endtask
endmodule

// File: tb/test_psr_top.sv
// Self-checking bench of the pixel shutter and readout control block.
// Assumes the controller model drives all pins but mclk and rst_b; array shrunk to 8 x 8.
`timescale 1ns/1ps
`include "psr_cfg.svh"

module test_psr_top;
  localparam int ROWS = 8;
  localparam int COLS = 8;
  logic                   mclk = 1'b0;
  logic                   rst_b = 1'b0;
  logic memory_boost_n, full_reset, dual_slope_reset, precharge_n, sample_n;
  logic frame_sync, row_clk, line_sync, pixel_clk;
  logic cfg_sclk, cfg_sdata, cfg_load;
  logic mem_bias_high, pixel_reset_on, reset_full_level;
  logic partial_reset_supply, precharge_on, sample_on, line_end, frame_end;
  logic [`PSR_ADDR_W-1:0] row_addr, col_addr;
  logic [`PSR_CFG_W-1:0]  cfg_word;
  logic [31:0]            seed = 32'h0000_0016;
  int                     fail_count = 0, compares = 0, n_le = 0, n_fe = 0;

  psr_ctl_model i_ctl (.mclk, .memory_boost_n, .full_reset, .dual_slope_reset,
    .precharge_n, .sample_n, .frame_sync, .row_clk, .line_sync, .pixel_clk,
    .cfg_sclk, .cfg_sdata, .cfg_load);

  psr_top #(.ROWS(ROWS), .COLS(COLS)) i_dut (.mclk, .rst_b, .memory_boost_n,
    .full_reset, .dual_slope_reset, .precharge_n, .sample_n, .frame_sync,
    .row_clk, .line_sync, .pixel_clk, .cfg_sclk, .cfg_sdata, .cfg_load,
    .mem_bias_high, .pixel_reset_on, .reset_full_level, .partial_reset_supply,
    .precharge_on, .sample_on, .row_addr, .col_addr, .line_end, .frame_end,
    .cfg_word);

  always #20 mclk = ~mclk;

  // End flags last one cycle, so they are counted rather than sampled
  always @(posedge mclk) begin
    if (line_end === 1'b1)
      n_le++;
    if (frame_end === 1'b1)
      n_fe++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int exp_addr(input bit col, input int st, input int k);
    return col ? (2 * st + 2 * k) % COLS : (2 * st + k) % ROWS;
  endfunction

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic scan(input bit col, input int st, input int n, input int fl);
    int          e0;
    logic [31:0] a;
    e0 = n_le + n_fe;
    i_ctl.sync(col);
    a = col ? col_addr : row_addr;
    check("start addr", exp_addr(col, st, 0), a);
    for (int k = 1; k <= n; k++) begin
      i_ctl.step(col, 1);
      a = col ? col_addr : row_addr;
      check("addr", exp_addr(col, st, k), a);
    end
    check("end flags", e0 + fl, n_le + n_fe);
  endtask

  initial begin
    logic [31:0] w;
    logic [31:0] old;
    logic [4:0]  p;
    int          tbl [5][4];
    // Axis, start, steps, flags: early sync, full, windowed
    tbl = '{'{0, 0, 3, 0}, '{0, 0, 8, 1}, '{0, 1, 6, 0},
            '{1, 0, 4, 1}, '{1, 2, 2, 0}};
    old = `PSR_CFG_RST;
    repeat (10) @(posedge mclk);
    #1;
    check("reset bias", 0, mem_bias_high);
    check("reset addr", 0, row_addr);
    check("reset cfg", 0, cfg_word);
    check("reset flags", 0, {pixel_reset_on, line_end, frame_end});
    rst_b = 1'b1;
    i_ctl.tick(3);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      p = {seed[2:0], 2'(i)};
      i_ctl.levels(p);
      i_ctl.tick(5);
      check("bias", p[2], mem_bias_high);
      check("reset on", p[0] | p[1], pixel_reset_on);
      check("full level", p[0], reset_full_level);
      check("partial", p[1] & !p[0], partial_reset_supply);
      check("precharge", !p[3], precharge_on);
      check("sample", !p[4], sample_on);
    end
    i_ctl.levels(5'h1C);
    i_ctl.transfer();
    check("bias after", 1, mem_bias_high);
    fork
      i_ctl.dual_pulse();
      begin
        i_ctl.tick(10);
        check("dual supply", 1, partial_reset_supply);
      end
    join
    foreach (tbl[i]) begin
      seed = lfsr(seed);
      w = seed;
      w[0] = 1'b0;
      w[13] = 1'b0;
      w[10:1] = 10'(tbl[i][1]);
      w[23:14] = 10'(tbl[i][1]);
      i_ctl.shift(w);
      check("cfg held", old, cfg_word);
      i_ctl.load();
      check("cfg", w, cfg_word);
      old = w;
      scan(tbl[i][0] != 0, tbl[i][1], tbl[i][2], tbl[i][3]);
    end
    summarize();
  end

  initial begin
    #400000;
    fail_count++;
    summarize();
  end
endmodule
